// ===== design/wms_pkg.sv
// Package for the warning mask and signal source selector
package wms_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_MASK_CMD    = 4'h0;  // Mask command, write
    localparam logic [3:0]  ADDR_ACTIVE_MASK = 4'h1;  // Active condition mask, read
    localparam logic [3:0]  ADDR_SRC_SEL     = 4'h2;  // Selected signal source
    localparam logic [3:0]  ADDR_MFI_MODE    = 4'h3;  // Multifunction input mode
    localparam logic [3:0]  ADDR_REMOTE      = 4'h4;  // Remote control bits
    localparam logic [3:0]  ADDR_CONFIG      = 4'h5;  // Configuration number
    localparam logic [3:0]  ADDR_STATUS      = 4'h6;  // Selected source level and combined warning signal

    // ------------------------------------------------------------
    // Mask command codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_NO_CHANGE    = 8'h00;
    localparam logic [7:0]  CMD_ALL          = 8'h01;
    localparam logic [7:0]  CMD_ALL_WARN     = 8'h02;
    localparam logic [7:0]  CMD_ALL_STATE    = 8'h03;
    localparam logic [7:0]  CMD_WARN_FIRST   = 8'h0a;  // 10
    localparam logic [7:0]  CMD_WARN_LAST    = 8'h19;  // 25
    localparam logic [7:0]  CMD_STATE_FIRST  = 8'h1e;  // 30
    localparam logic [7:0]  CMD_STATE_LAST   = 8'h2b;  // 43
    localparam logic [7:0]  CMD_STATE_OFFSET = 8'h0e;  // 14
    localparam logic [7:0]  CMD_REMOVE_FIRST = 8'h65;  // 101
    localparam logic [7:0]  CMD_REMOVE_LAST  = 8'h8f;  // 143
    localparam logic [7:0]  CMD_REMOVE_BASE  = 8'h64;  // 100

    // ------------------------------------------------------------
    // Mask layout and values
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_RESET       = 32'h0000_0000;
    localparam logic [31:0] MASK_ALL         = 32'hffff_ffff;
    localparam logic [31:0] MASK_WARN        = 32'h0000_ffff;
    localparam logic [31:0] MASK_STATE       = 32'hffff_0000;
    localparam logic [31:0] MASK_ASSIGNED    = 32'h3fff_ffff;  // Bits 30 and 31 unused
    localparam int          BIT_LONG_LIMIT   = 25;  // Code 39, long-term 60 s limit
    localparam int          BIT_SHORT_LIMIT  = 26;  // Code 40, short-term 1 s limit

    // ------------------------------------------------------------
    // Signal source numbers
    // ------------------------------------------------------------
    localparam logic [7:0]  SRC_ON           = 8'h06;  // 6
    localparam logic [7:0]  SRC_OFF          = 8'h07;  // 7
    localparam logic [7:0]  SRC_TECH_START   = 8'h0d;  // 13
    localparam logic [7:0]  SRC_FAULT        = 8'h3d;  // 61
    localparam logic [7:0]  SRC_DIN_FIRST    = 8'h46;  // 70
    localparam logic [7:0]  SRC_DIN_LAST     = 8'h4b;  // 75
    localparam logic [7:0]  SRC_MFI          = 8'h4c;  // 76
    localparam logic [7:0]  SRC_WARN_MASK    = 8'h9d;  // 157
    localparam logic [7:0]  MFI_MODE_DIGITAL = 8'h03;
    localparam logic [9:0]  CFG_TECH_A       = 10'h06f;  // 111
    localparam logic [9:0]  CFG_TECH_B       = 10'h19b;  // 411
    localparam logic [9:0]  CFG_RESET        = 10'h06f;
    localparam logic [7:0]  SRC_SEL_RESET    = 8'h07;

    // Register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wms_bus_s;

endpackage

// ===== design/wms_top.sv
// Warning mask builder and digital signal source selector
// How it works
// - Code 1 sets every mask bit.
// - Code 2 loads lower sixteen bits set, upper cleared.
// - Code 3 loads upper sixteen bits set, lower cleared.
// - Codes 10 to 25 set mask bit code minus 10.
// - Codes 30 to 43 set mask bit code minus 14.
// - Codes 110 to 125 and 130 to 143 clear the bit their code minus 100 sets.
// - Current mask is readable at any time.
// - Single-bit commands accumulate into the mask.
// - Code 0 leaves the mask untouched.
// - Source 157 is high when any enabled condition is active.
// - State inputs 39 and 40 flag long and short overload limiting.
// - Source 6 is constant high, source 7 constant low.
// - Source 70 follows digital input one.
// - Sources 71 to 75 follow inputs two to six or remote bits.
// - Source 76 follows multifunction input only in mode 3, else remote.
// - Source 61 is high while a fault is reported.
// - Source 13 carries tech start only in configurations 111 and 411.
// - Any source number is selectable in every configuration; only source 13 depends on it.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
module wms_top
    import wms_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Condition flags from monitoring, same clock
    input  wire logic [15:0] warning_flags,
    input  wire logic [13:0] state_flags,
    input  wire logic        fault_flag,
    input  wire logic        tech_start,
    // Pins
    input  wire logic        digital_in_one,
    input  wire logic        digital_in_two,
    input  wire logic        digital_in_three,
    input  wire logic        digital_in_four,
    input  wire logic        digital_in_five,
    input  wire logic        digital_in_six,
    input  wire logic        multifunction_in_one,
    // Results
    output logic             warn_mask_signal,
    output logic             selected_signal,
    output logic             long_overload_limit_state,
    output logic             short_overload_limit_state
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One-hot bit from an index
    function automatic logic [31:0] bit_of(input logic [7:0] idx);
        bit_of = 32'h0000_0001 << idx[4:0];
    endfunction

    // Mask bit that a set code names, zero if none
    function automatic logic [31:0] code_bit(input logic [7:0] code);
        code_bit = 32'h0000_0000;
        if (code >= CMD_WARN_FIRST && code <= CMD_WARN_LAST) begin
            code_bit = bit_of(8'(code - CMD_WARN_FIRST));
        end else if (code >= CMD_STATE_FIRST && code <= CMD_STATE_LAST) begin
            code_bit = bit_of(8'(code - CMD_STATE_OFFSET));
        end
    endfunction

    wms_bus_s bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pin_raw;
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    assign pin_raw = {multifunction_in_one, digital_in_six, digital_in_five,
                      digital_in_four, digital_in_three, digital_in_two, digital_in_one};

    // Two flops per pin
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_meta <= 7'h00;
            pin_sync <= 7'h00;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers and mask
    // ------------------------------------------------------------
    logic [31:0] cond_mask;
    logic [31:0] next_cond_mask;
    logic [7:0]  src_sel;
    logic [7:0]  next_src_sel;
    logic [7:0]  mfi_mode;
    logic [7:0]  next_mfi_mode;
    logic [5:0]  remote;
    logic [5:0]  next_remote;
    logic [9:0]  config_num;
    logic [9:0]  next_config_num;
    logic [7:0]  cmd;
    assign cmd = bus.wdata[7:0];

    // Next values of the software state
    always_comb begin
        next_cond_mask  = cond_mask;
        next_src_sel    = src_sel;
        next_mfi_mode   = mfi_mode;
        next_remote     = remote;
        next_config_num = config_num;
        if (bus.wr) begin
            unique case (bus.addr)
                ADDR_MASK_CMD: begin
                    if (cmd == CMD_NO_CHANGE) begin
                        next_cond_mask = cond_mask;
                    end else if (cmd == CMD_ALL) begin
                        next_cond_mask = MASK_ALL;
                    end else if (cmd == CMD_ALL_WARN) begin
                        next_cond_mask = MASK_WARN;
                    end else if (cmd == CMD_ALL_STATE) begin
                        next_cond_mask = MASK_STATE;
                    end else if (cmd >= CMD_REMOVE_FIRST && cmd <= CMD_REMOVE_LAST) begin
                        next_cond_mask = cond_mask & ~code_bit(8'(cmd - CMD_REMOVE_BASE));
                    end else begin
                        next_cond_mask = cond_mask | code_bit(cmd);
                    end
                end
                ADDR_SRC_SEL:  next_src_sel    = bus.wdata[7:0];
                ADDR_MFI_MODE: next_mfi_mode   = bus.wdata[7:0];
                ADDR_REMOTE:   next_remote     = bus.wdata[5:0];
                ADDR_CONFIG:   next_config_num = bus.wdata[9:0];
                default: ;
            endcase
        end
    end

    // Register the software state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cond_mask  <= MASK_RESET;
            src_sel    <= SRC_SEL_RESET;
            mfi_mode   <= 8'h00;
            remote     <= 6'h00;
            config_num <= CFG_RESET;
        end else begin
            cond_mask  <= next_cond_mask;
            src_sel    <= next_src_sel;
            mfi_mode   <= next_mfi_mode;
            remote     <= next_remote;
            config_num <= next_config_num;
        end
    end

    // ------------------------------------------------------------
    // Combined warning signal and source selection
    // ------------------------------------------------------------
    logic [31:0] cond_flags;
    logic [5:0]  din_level;
    logic        tech_cfg;
    logic        next_warn;
    logic        next_sel;
    assign cond_flags = {2'b00, state_flags, warning_flags};
    assign tech_cfg   = (config_num == CFG_TECH_A) || (config_num == CFG_TECH_B);

    // Input one is the release input, no remote path; others OR remote
    always_comb begin
        din_level[0] = pin_sync[0];
        for (int i = 1; i < 6; i++) begin
            din_level[i] = pin_sync[i] | remote[i];
        end
    end

    // Next combined signal and selected source level
    always_comb begin
        next_warn = |(cond_flags & cond_mask & MASK_ASSIGNED);
        next_sel  = 1'b0;
        if (src_sel == SRC_ON) begin
            next_sel = 1'b1;
        end else if (src_sel == SRC_OFF) begin
            next_sel = 1'b0;
        end else if (src_sel == SRC_TECH_START) begin
            next_sel = tech_cfg & tech_start;
        end else if (src_sel == SRC_FAULT) begin
            next_sel = fault_flag;
        end else if (src_sel >= SRC_DIN_FIRST && src_sel <= SRC_DIN_LAST) begin
            next_sel = din_level[3'(src_sel - SRC_DIN_FIRST)];
        end else if (src_sel == SRC_MFI) begin
            next_sel = (mfi_mode == MFI_MODE_DIGITAL) ? pin_sync[6] : remote[0];
        end else if (src_sel == SRC_WARN_MASK) begin
            next_sel = next_warn;
        end
    end

    // Register outputs and read data
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_ACTIVE_MASK: next_rdata = cond_mask;
                ADDR_SRC_SEL:     next_rdata = {24'h000000, src_sel};
                ADDR_MFI_MODE:    next_rdata = {24'h000000, mfi_mode};
                ADDR_REMOTE:      next_rdata = {26'h0, remote};
                ADDR_CONFIG:      next_rdata = {22'h0, config_num};
                ADDR_STATUS:      next_rdata = {30'h0, selected_signal, warn_mask_signal};
                default:          next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            warn_mask_signal           <= 1'b0;
            selected_signal            <= 1'b0;
            rdata                      <= 32'h0000_0000;
            long_overload_limit_state  <= 1'b0;
            short_overload_limit_state <= 1'b0;
        end else begin
            warn_mask_signal           <= next_warn;
            selected_signal            <= next_sel;
            rdata                      <= next_rdata;
            long_overload_limit_state  <= cond_flags[BIT_LONG_LIMIT];
            short_overload_limit_state <= cond_flags[BIT_SHORT_LIMIT];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Enabled and active conditions, watched one cycle later by the checker
    logic [31:0] live_cond;
    assign live_cond = cond_flags & cond_mask & MASK_ASSIGNED;

    sequence s_cmd(logic [7:0] c);
        bus.wr && bus.addr == ADDR_MASK_CMD && cmd == c;
    endsequence

    a_mask_all_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(CMD_ALL) |=> cond_mask == MASK_ALL) else $error("mask not all set");
    a_mask_warn_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(CMD_ALL_WARN) |=> cond_mask == MASK_WARN) else $error("warn mask wrong");
    a_mask_state_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(CMD_ALL_STATE) |=> cond_mask == MASK_STATE) else $error("state mask wrong");
    a_warn_bit_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(CMD_WARN_FIRST) |=> cond_mask[0] && (cond_mask | 32'h1) == ($past(cond_mask) | 32'h1))
        else $error("code 10 wrong");
    a_state_bit_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(CMD_STATE_FIRST) |=> cond_mask[16]) else $error("code 30 wrong");
    a_remove_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(8'(CMD_REMOVE_BASE + CMD_WARN_FIRST)) |=> !cond_mask[0]) else $error("code 110 wrong");
    a_no_change: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_cmd(CMD_NO_CHANGE) |=> $stable(cond_mask)) else $error("code 0 changed mask");
    a_mask_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus.rd && bus.addr == ADDR_ACTIVE_MASK |=> rdata == $past(cond_mask)) else $error("bad readback");
    a_combined_sig: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 warn_mask_signal == ($past(live_cond) != 32'h0000_0000)) else $error("bad combine");
    a_const_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        src_sel == SRC_ON ##1 src_sel == SRC_ON |-> selected_signal) else $error("on source low");

endmodule

// ===== tb/wms_cond_model.sv
// Monitoring side model that supplies condition flags to the mask block
module wms_cond_model
    import wms_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Wanted condition levels from the bench
    input  wire logic [31:0] stim,
    // Condition flags
    output logic      [15:0] warning_flags,
    output logic      [13:0] state_flags,
    output logic             fault_flag,
    output logic             tech_start
);
    timeunit 1ns;
    timeprecision 1ps;

    // Flags change on the clock like real monitoring outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            warning_flags <= 16'h0000;
            state_flags   <= 14'h0000;
            fault_flag    <= 1'b0;
            tech_start    <= 1'b0;
        end else begin
            warning_flags <= stim[15:0];
            state_flags   <= stim[29:16];  // Bits 9 and 10 are long and short overload limiting
            fault_flag    <= stim[30];
            tech_start    <= stim[31];
        end
    end
endmodule

// ===== tb/wms_top_test.sv
// Self-checking bench for the warning mask and source selector
module wms_top_test
    import wms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] warning_flags;
    logic [13:0] state_flags;
    logic        fault_flag;
    logic        tech_start;
    logic [31:0] stim = 32'h0000_0000;
    logic [5:0]  din = 6'h00;
    logic        mfi = 1'b0;
    logic        warn_mask_signal;
    logic        selected_signal;
    logic        long_lim;
    logic        short_lim;
    logic [31:0] lfsr = 32'h8823_8945;
    logic [31:0] m;
    logic [31:0] d;
    logic [31:0] e;
    logic [7:0]  c;
    logic [5:0]  rem;
    int          err_count = 0;
    int          checks = 0;
    logic [7:0]  corner [14] = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h0a, 8'h19, 8'h1e, 8'h2b, 8'h04, 8'h1a,
                                 8'h2c, 8'h8f, 8'h6e, 8'hc8};
    logic [7:0]  srcs [14] = '{8'h06, 8'h07, 8'h0d, 8'h3d, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b,
                               8'h4c, 8'h9d, 8'h08, 8'h00};
    logic [9:0]  cfgs [3] = '{10'h06f, 10'h19b, 10'h01e};

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Design and monitoring model
    // ------------------------------------------------------------
    wms_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .warning_flags(warning_flags), .state_flags(state_flags), .fault_flag(fault_flag),
        .tech_start(tech_start), .digital_in_one(din[0]), .digital_in_two(din[1]),
        .digital_in_three(din[2]), .digital_in_four(din[3]), .digital_in_five(din[4]),
        .digital_in_six(din[5]), .multifunction_in_one(mfi), .warn_mask_signal(warn_mask_signal),
        .selected_signal(selected_signal), .long_overload_limit_state(long_lim),
        .short_overload_limit_state(short_lim));

    wms_cond_model u_model (.sys_clk(sys_clk), .rst_n(rst_n), .stim(stim), .warning_flags(warning_flags),
        .state_flags(state_flags), .fault_flag(fault_flag), .tech_start(tech_start));

    // ------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction

    // Mask after one command code
    function automatic logic [31:0] exp_mask(input logic [31:0] mk, input logic [7:0] code);
        int n;
        n = code;
        if (n == 1) return 32'hffff_ffff;
        if (n == 2) return 32'h0000_ffff;
        if (n == 3) return 32'hffff_0000;
        if (n >= 10 && n <= 25) return mk | (32'h1 << (n - 10));
        if (n >= 30 && n <= 43) return mk | (32'h1 << (n - 14));
        if (n >= 110 && n <= 125) return mk & ~(32'h1 << (n - 110));
        if (n >= 130 && n <= 143) return mk & ~(32'h1 << (n - 114));
        return mk;
    endfunction

    // Level of one signal source
    function automatic logic exp_src(input logic [7:0] s, input logic [9:0] cf, input logic [7:0] md,
                                     input logic [5:0] r, input logic wm);
        int k;
        k = s;
        if (k == 6) return 1'b1;
        if (k == 13) return (cf == 10'h06f || cf == 10'h19b) & stim[31];
        if (k == 61) return stim[30];
        if (k == 70) return din[0];
        if (k >= 71 && k <= 75) return din[k - 70] | r[k - 70];
        if (k == 76) return (md == 8'h03) ? mfi : r[0];
        if (k == 157) return wm;
        return 1'b0;
    endfunction

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        m = 32'h0000_0000;
        rd_reg(ADDR_ACTIVE_MASK, d);
        check("mask_reset", 32'h0000_0000, d);
        wr_reg(4'hf, 32'hffff_ffff);
        rd_reg(4'hf, d);
        check("unmapped", 32'h0000_0000, d);
        // Corner codes first, then random legal and ignored codes
        for (int i = 0; i < 74; i++) begin
            lfsr = lfsr_next(lfsr);
            c = (i < 14) ? corner[i] : 8'(lfsr % 144);
            if (c >= 8'h65 && c <= 8'h67) c = 8'h00;
            wr_reg(ADDR_MASK_CMD, {24'h0, c});
            m = exp_mask(m, c);
            rd_reg(ADDR_ACTIVE_MASK, d);
            check("mask", m, d);
        end
        // Combined signal against random flags and masks
        for (int i = 0; i < 30; i++) begin
            lfsr = lfsr_next(lfsr);
            c = (i == 0) ? 8'h01 : 8'(lfsr % 44);
            wr_reg(ADDR_MASK_CMD, {24'h0, c});
            m = exp_mask(m, c);
            lfsr = lfsr_next(lfsr);
            @(posedge sys_clk);
            stim <= (i == 0) ? 32'h0000_0000 : (lfsr & {2'b11, 30'(lfsr_next(lfsr) & lfsr)});
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            check("warn_sig", {31'h0, |(stim[29:0] & m[29:0])}, {31'h0, warn_mask_signal});
            check("long_lim", {31'h0, stim[25]}, {31'h0, long_lim});
            check("short_lim", {31'h0, stim[26]}, {31'h0, short_lim});
        end
        // Every source in each configuration and input mode
        for (int f = 0; f < 6; f++) begin
            wr_reg(ADDR_CONFIG, {22'h0, cfgs[f / 2]});
            wr_reg(ADDR_MFI_MODE, (f % 2 == 0) ? 32'h3 : 32'h0);
            rd_reg(ADDR_CONFIG, d);
            check("config", {22'h0, cfgs[f / 2]}, d);
            for (int s = 0; s < 14; s++) begin
                lfsr = lfsr_next(lfsr);
                rem = lfsr[13:8];
                wr_reg(ADDR_REMOTE, {26'h0, rem});
                wr_reg(ADDR_SRC_SEL, {24'h0, srcs[s]});
                @(posedge sys_clk);
                din <= lfsr[5:0];
                mfi <= lfsr[6];
                stim <= lfsr_next(lfsr);
                repeat (6) @(posedge sys_clk);
                @(negedge sys_clk);
                e = {31'h0, exp_src(srcs[s], cfgs[f / 2], (f % 2 == 0) ? 8'h03 : 8'h00, rem,
                                    |(stim[29:0] & m[29:0]))};
                check("selected", e, {31'h0, selected_signal});
                rd_reg(ADDR_STATUS, d);
                check("status_sel", e, {31'h0, d[1]});
                check("status_warn", {31'h0, |(stim[29:0] & m[29:0])}, {31'h0, d[0]});
            end
        end
        stop_test();
    end
endmodule
